/* File: bench/mief_evt_model.sv */
// Purpose: event-source side of the interrupt enable and flag unit
// Assumes: the bench raises one fire bit for one cycle per event
// Notes: fire bits follow the event struct order, msb timer A
module mief_evt_model (
  input wire logic i_clk,
  input wire logic [7:0] i_fire,
  output mief_pkg::mief_events_t o_events
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // event generation
  logic [7:0] ev_ff = 8'h00; // struct image; starts known, no reset pin
  // pulses last one cycle; the comparator levels keep their new value,
  // so each fire on bits 3:2 is exactly one output change
  always_ff @(posedge i_clk) begin
    ev_ff <= (i_fire & 8'hF3) | {4'h0, ev_ff[3:2] ^ i_fire[3:2], 2'h0};
  end
  assign o_events = ev_ff;
endmodule

/* File: bench/tb.sv */
// Purpose: self-checking bench of the interrupt enable and flag unit
// Assumes: AXI4-Lite master here, event sources in the partner model
// Notes: register contents are tracked in integers and compared
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // stimulus and observation
  logic clk = 1'b0;
  logic rst = 1'b1; // pin or watchdog reset
  logic por = 1'b1; // power-on reset, loads the port latch
  logic pin = 1'b0;
  logic [5:0] port = 6'h00;
  logic [7:0] fire = 8'h00;
  mief_pkg::mief_events_t ev;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bry = 1'b0;
  logic arv = 1'b0;
  logic rry = 1'b0;
  logic [31:0] awa = 32'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] ara = 32'h0;
  logic [3:0] strb = 4'hF; // write strobes, lane 0 carries the register
  logic awr, wr_rdy, bv, arr, rv, irq;
  logic [31:0] rd;
  logic [1:0] br, rr, resp;
  logic [31:0] got;
  logic [31:0] seed = 32'h0000261C;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int m_core = 0; // model of the core control register
  int m_pf = 0; // model of the peripheral flags
  int m_pe = 0; // model of the peripheral enables
  int pos;
  mief_evt_model src (.i_clk(clk), .i_fire(fire), .o_events(ev));
  mief_top dut (.I_CLK(clk), .I_RESET(rst), .I_POR(por), .I_EVENTS(ev),
    .I_EXT_IRQ_PIN(pin), .I_IO_PORT_A(port), .I_AWVALID(awv),
    .O_AWREADY(awr), .I_AWADDR(awa), .I_AWPROT(3'h0), .I_WVALID(wv),
    .O_WREADY(wr_rdy), .I_WDATA(wd), .I_WSTRB(strb), .O_BVALID(bv),
    .I_BREADY(bry), .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr),
    .I_ARADDR(ara), .I_ARPROT(3'h0), .O_RVALID(rv), .I_RREADY(rry),
    .O_RDATA(rd), .O_RRESP(rr), .O_IRQ(irq));
  initial begin
    forever #5 clk = ~clk;
  end
  // hang guard: the whole run needs under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // readies are sampled at the falling edge: they only move on rising
  // edges, so this is the value the next rising edge sees, race free
  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge clk);
      ah = awv & awr;
      wh = wv & wr_rdy;
      bh = bv;
      resp = br;
      @(posedge clk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
    end
    bry <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axr(input logic [31:0] a);
    logic ah, rh;
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge clk);
      ah = arv & arr;
      rh = rv;
      got = rd;
      resp = rr;
      @(posedge clk);
      if (ah) arv <= 1'b0;
    end
    rry <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] a, input int d);
    axw(a, 32'(d));
    chk(32'(resp), 32'(mief_pkg::RESP_OKAY));
  endtask
  task automatic rdc(input logic [31:0] a, input int e);
    axr(a);
    chk(32'(resp), 32'(mief_pkg::RESP_OKAY));
    chk(got, 32'(e));
  endtask
  task automatic pulse(input int k);
    fire <= 8'(8'h01 << k);
    @(posedge clk);
    fire <= 8'h00;
    repeat (4) @(posedge clk);
  endtask
  task automatic wait_pins();
    repeat (6) @(posedge clk);
  endtask
  // request expected from the model, one edge after the registers
  task automatic chk_irq();
    int e;
    e = (m_core >> 7) & ((((m_core >> 3) & m_core & 7) != 0) |
      (((m_core >> 6) & 1) & ((m_pe & m_pf & 8'hFD) != 0)));
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({31'h0, irq}, 32'(e));
    @(posedge clk);
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge clk);
    rdc(32'h2C, 0);
    rdc(32'h22C, 0);
    rdc(32'h30, 0);
    rdc(32'h230, 0);
    rdc(32'h44, 32'h40);
    axr(32'h3FC);
    chk(32'(resp), 32'(mief_pkg::RESP_SLVERR));
    axw(32'h3FC, 32'hFF);
    chk(32'(resp), 32'(mief_pkg::RESP_SLVERR));
    // lane 0 strobe low: the write is answered but nothing is stored
    strb <= 4'hE;
    wr(32'h2C, 32'hFF);
    strb <= 4'hF;
    rdc(32'h2C, 0);
    $display("test reset_values done");
    // every peripheral source with all enables low; flags accumulate
    for (int b = 7; b >= 0; b--) begin
      if (b != 1) begin
        pos = (b == 0) ? 0 : b - 1;
        pulse(pos);
        m_pf |= 1 << b;
        rdc(32'h30, m_pf);
        chk_irq();
      end
    end
    wr(32'h30, 0);
    rdc(32'h30, 0);
    // clearing write and oscillator failure land on one edge: set wins
    fork
      wr(32'h30, 0);
      begin
        fire <= 8'h02;
        @(posedge clk);
        fire <= 8'h00;
      end
    join
    rdc(32'h30, 32'h04);
    wr(32'h30, 0);
    m_pf = 0;
    pulse(7);
    rdc(32'h2C, 32'h04);
    wr(32'h2C, 0);
    $display("test event_flags done");
    // external pin: rising select after reset, then falling select
    pin <= 1'b1;
    wait_pins();
    rdc(32'h2C, 32'h02);
    wr(32'h2C, 0);
    pin <= 1'b0;
    wait_pins();
    rdc(32'h2C, 0);
    wr(32'h44, 0);
    pin <= 1'b1;
    wait_pins();
    rdc(32'h2C, 0);
    pin <= 1'b0;
    wait_pins();
    rdc(32'h2C, 32'h02);
    wr(32'h2C, 0);
    $display("test ext_pin done");
    // port change: unselected pin ignored, mismatch persists
    port <= 6'h08;
    wait_pins();
    rdc(32'h2C, 0);
    wr(32'h40, 32'h08);
    rdc(32'h2C, 32'h01);
    wr(32'h2C, 0);
    rdc(32'h2C, 32'h01);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(32'h2C, 0);
    wr(32'h40, 32'h08);
    rdc(32'h2C, 32'h01);
    rdc(32'h48, 32'h08);
    wr(32'h2C, 0);
    rdc(32'h2C, 0);
    $display("test port_change done");
    // random enables and flags through both core addresses
    for (int i = 0; i < 24; i++) begin
      m_core = rnd() & 32'hFF;
      m_pf = rnd() & 32'hFF;
      m_pe = rnd() & 32'hFF;
      wr(i[0] ? 32'h22C : 32'h2C, m_core);
      wr(32'h30, m_pf);
      wr(32'h230, m_pe);
      rdc(i[0] ? 32'h2C : 32'h22C, m_core);
      rdc(32'h30, m_pf & 32'hFD);
      rdc(32'h230, m_pe & 32'hFD);
      chk_irq();
    end
    $display("test irq_gating done");
    final_report();
  end
endmodule

/* File: rtl/mief_pkg.sv */
// Purpose: constants and types of the interrupt enable and flag unit
// Assumes: registers are 8 bits wide, one per aligned 32-bit word
// Notes: offsets are word indices; byte address is four times the index
package mief_pkg;
  // ==========================================================
  // register indices
  localparam logic [7:0] IDX_CORE_LO = 8'h0B; // core control, bank 0
  localparam logic [7:0] IDX_CORE_HI = 8'h8B; // core control, bank 1
  localparam logic [7:0] IDX_PFLAGS = 8'h0C; // peripheral flags
  localparam logic [7:0] IDX_PENABLES = 8'h8C; // peripheral enables
  localparam logic [7:0] IDX_PIN_EN = 8'h10; // per-pin change enables
  localparam logic [7:0] IDX_OPTION = 8'h11; // edge select option
  localparam logic [7:0] IDX_PORT = 8'h12; // port value, read updates latch
  // ==========================================================
  // core control bit positions
  localparam int B_GIE = 7;
  localparam int B_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int B_TA_EN = 5;
  localparam int B_EXT_EN = 4;
  localparam int B_PC_EN = 3;
  localparam int B_TA_FLAG = 2;
  localparam int B_EXT_FLAG = 1;
  localparam int B_PC_FLAG = 0;
  // ==========================================================
  // peripheral bit positions, shared by flags and enables
  localparam int B_EEPROM = 7;
  localparam int B_LOWV = 6;
  localparam int B_CIPHER = 5;
  localparam int B_COMP_B = 4;
  localparam int B_COMP_A = 3;
  localparam int B_OSCF = 2;
  localparam int B_UNUSED = 1;
  localparam int B_TIMER_B = 0;
  localparam int B_EDGE_SEL = 6; // within the option register
  // ==========================================================
  // reset values and masks
  localparam logic [7:0] RST_CORE = 8'h00;
  localparam logic [7:0] RST_PERIPH = 8'h00;
  localparam logic [5:0] RST_PIN_EN = 6'h00;
  localparam logic RST_EDGE_SEL = 1'b1; // rising edge after reset
  localparam logic [7:0] PERIPH_MASK = 8'hFD; // bit 1 not built
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // peripheral event sources, all on the system clock
  typedef struct packed {
    logic timer_a_ovf; // one-cycle rollover pulse
    logic eeprom_done; // one-cycle write-complete pulse
    logic low_volt; // one-cycle threshold crossing pulse
    logic cipher_done; // one-cycle completion pulse
    logic comparator_b_output; // level
    logic comparator_a_output; // level
    logic osc_fail; // one-cycle failover pulse
    logic timer_b_roll; // one-cycle rollover pulse
  } mief_events_t;
endpackage

/* File: rtl/mief_top.sv */
// Purpose: interrupt enable/flag registers and request to the core
// Assumes: event sources run on I_CLK; port and ext pin are asynchronous
// Notes: AXI4-Lite slave, 8-bit registers in the low byte of each word
// How it works
// RULE_01: flags set on events regardless of enables
// RULE_02: global enable gates every interrupt request
// RULE_03: peripheral enable gates all peripheral requests
// RULE_04: timer A enable bit5, flag bit2
// RULE_05: external pin enable bit4, flag bit1
// RULE_06: port change enable bit3, flag bit0
// RULE_07: only selected pins may raise port change
// RULE_08: port flag clears on reset, sets on mismatch
// RULE_09: bit7 is eeprom write complete
// RULE_10: bit6 is low voltage detect
// RULE_11: bit5 is cipher unit done
// RULE_12: bit4 is comparator B change
// RULE_13: bit3 is comparator A change
// RULE_14: bit2 is oscillator failure
// RULE_15: bit0 is timer B rollover
// RULE_16: peripheral bit1 unbuilt, reads zero
// RULE_17: flags stay set until software clears
// RULE_18: software clears flag before enabling source
// RULE_19: core register mirrored in both banks
// RULE_20: edge select: 1 rising, 0 falling
// RULE_21: request is gated OR of enable-flag pairs
module mief_top #(
  parameter bit HAS_COMP_B = 1'b1 // comparator B exists on larger parts
) (
  input wire logic I_CLK,
  input wire logic I_RESET, // master-clear or watchdog reset
  input wire logic I_POR, // power-on reset, also loads port latch
  input wire mief_pkg::mief_events_t I_EVENTS,
  input wire logic I_EXT_IRQ_PIN,
  input wire logic [5:0] I_IO_PORT_A,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_AWADDR,
  input wire logic [2:0] I_AWPROT,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [31:0] I_ARADDR,
  input wire logic [2:0] I_ARPROT,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_IRQ // interrupt request to the core
);
  // ==========================================================
  // declarations
  logic rst; // any reset
  logic [7:0] core_ff, nxt_core; // core control register
  logic [7:0] pflags_ff, nxt_pflags; // peripheral flags
  logic [7:0] pen_ff; // peripheral enables
  logic [5:0] pin_en_ff; // per-pin change enables
  logic edge_sel_ff; // 1 rising, 0 falling
  logic [5:0] port_s1_ff, port_s2_ff; // port synchroniser
  logic [5:0] port_latch_ff; // previous-value latch, kept on I_RESET
  logic ext_s1_ff, ext_s2_ff, ext_prev_ff; // pin sync and history
  logic comp_a_prev_ff, comp_b_prev_ff; // comparator history
  logic irq_ff; // registered request
  logic aw_full_ff, w_full_ff; // captured write halves
  logic [31:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic wstrb0_ff;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic do_write; // both halves held, response slot free
  logic [7:0] widx; // word index of the write
  logic wr_core, wr_pflags, wr_pen; // write strobes per register
  logic ext_edge; // selected edge seen on the pin
  logic port_change; // enabled pin differs from latch
  logic rd_port; // read of port register, refreshes latch
  logic [7:0] ev_periph; // peripheral set terms

  assign rst = I_RESET | I_POR;

  // ==========================================================
  // address helpers
  // word index of a byte address; alignment is checked by is_mapped
  function automatic logic [7:0] word_idx(input logic [31:0] a);
    word_idx = a[9:2];
  endfunction

  // decodes whether an address hits a register
  function automatic logic is_mapped(input logic [31:0] a);
    logic [7:0] i;
    i = word_idx(a);
    is_mapped = (a[1:0] == 2'h0) && (a[31:10] == 22'h0) &&
      (i == mief_pkg::IDX_CORE_LO || i == mief_pkg::IDX_CORE_HI ||
       i == mief_pkg::IDX_PFLAGS || i == mief_pkg::IDX_PENABLES ||
       i == mief_pkg::IDX_PIN_EN || i == mief_pkg::IDX_OPTION ||
       i == mief_pkg::IDX_PORT);
  endfunction

  // ==========================================================
  // AXI4-Lite write channel
  // each half is taken once and held until the write is done and its response raised;
  // one write at a time keeps the slave small
  assign O_AWREADY = !aw_full_ff;
  assign O_WREADY = !w_full_ff;
  assign do_write = aw_full_ff && w_full_ff && !bvalid_ff;
  assign widx = word_idx(awaddr_ff);
  // byte lane 0 carries the register, other lanes are ignored
  assign wr_core = do_write && wstrb0_ff && is_mapped(awaddr_ff) &&
    (widx == mief_pkg::IDX_CORE_LO ||
     widx == mief_pkg::IDX_CORE_HI); // [RULE_19]
  assign wr_pflags = do_write && wstrb0_ff && is_mapped(awaddr_ff) &&
    widx == mief_pkg::IDX_PFLAGS;
  assign wr_pen = do_write && wstrb0_ff && is_mapped(awaddr_ff) &&
    widx == mief_pkg::IDX_PENABLES;

  // write address and data capture
  always_ff @(posedge I_CLK) begin
    if (rst) begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      awaddr_ff <= 32'h0;
      wdata_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
    end else if (do_write) begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
    end else begin
      if (I_AWVALID && !aw_full_ff) begin
        aw_full_ff <= 1'b1;
        awaddr_ff <= I_AWADDR;
      end
      if (I_WVALID && !w_full_ff) begin
        w_full_ff <= 1'b1;
        wdata_ff <= I_WDATA[7:0];
        wstrb0_ff <= I_WSTRB[0];
      end
    end
  end

  // write response
  always_ff @(posedge I_CLK) begin
    if (rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= mief_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= is_mapped(awaddr_ff) ? mief_pkg::RESP_OKAY :
        mief_pkg::RESP_SLVERR;
    end else if (I_BREADY) begin
      bvalid_ff <= 1'b0;
    end
  end
  assign O_BVALID = bvalid_ff;
  assign O_BRESP = bresp_ff;

  // ==========================================================
  // AXI4-Lite read channel
  assign O_ARREADY = !rvalid_ff;
  assign rd_port = I_ARVALID && !rvalid_ff && is_mapped(I_ARADDR) &&
    word_idx(I_ARADDR) == mief_pkg::IDX_PORT;

  // read data is sampled at the address handshake
  always_ff @(posedge I_CLK) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= mief_pkg::RESP_OKAY;
    end else if (I_ARVALID && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= is_mapped(I_ARADDR) ? mief_pkg::RESP_OKAY :
        mief_pkg::RESP_SLVERR;
      rdata_ff <= 32'h0;
      if (is_mapped(I_ARADDR)) begin
        case (word_idx(I_ARADDR))
          mief_pkg::IDX_CORE_LO, mief_pkg::IDX_CORE_HI: begin
            rdata_ff[7:0] <= core_ff; // [RULE_19]
          end
          mief_pkg::IDX_PFLAGS: begin
            rdata_ff[7:0] <= pflags_ff & mief_pkg::PERIPH_MASK; // [RULE_16]
          end
          mief_pkg::IDX_PENABLES: begin
            rdata_ff[7:0] <= pen_ff & mief_pkg::PERIPH_MASK; // [RULE_16]
          end
          mief_pkg::IDX_PIN_EN: begin
            rdata_ff[5:0] <= pin_en_ff;
          end
          mief_pkg::IDX_OPTION: begin
            rdata_ff[mief_pkg::B_EDGE_SEL] <= edge_sel_ff;
          end
          mief_pkg::IDX_PORT: begin
            rdata_ff[5:0] <= port_s2_ff;
          end
          default: begin
            rdata_ff <= 32'h0;
          end
        endcase
      end
    end else if (I_RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign O_RVALID = rvalid_ff;
  assign O_RDATA = rdata_ff;
  assign O_RRESP = rresp_ff;

  // ==========================================================
  // pin synchronisers and edge detection
  // first stage is read only by the second stage
  always_ff @(posedge I_CLK) begin
    port_s1_ff <= I_IO_PORT_A;
    port_s2_ff <= port_s1_ff;
    ext_s1_ff <= I_EXT_IRQ_PIN;
    ext_s2_ff <= ext_s1_ff;
  end

  // pin and comparator history; loaded at reset so no false edge
  always_ff @(posedge I_CLK) begin
    if (rst) begin
      ext_prev_ff <= ext_s2_ff;
      comp_a_prev_ff <= I_EVENTS.comparator_a_output;
      comp_b_prev_ff <= I_EVENTS.comparator_b_output;
    end else begin
      ext_prev_ff <= ext_s2_ff;
      comp_a_prev_ff <= I_EVENTS.comparator_a_output;
      comp_b_prev_ff <= I_EVENTS.comparator_b_output;
    end
  end

  // selected edge on the external pin
  assign ext_edge = edge_sel_ff ? (ext_s2_ff && !ext_prev_ff) :
    (!ext_s2_ff && ext_prev_ff); // [RULE_20]

  // previous-value latch: only power-on loads it at reset, so a
  // mismatch left across a pin or watchdog reset sets the flag again
  always_ff @(posedge I_CLK) begin
    if (I_POR || rd_port) begin
      port_latch_ff <= port_s2_ff; // [RULE_08]
    end
  end

  // unselected pins never contribute
  assign port_change =
    |((port_s2_ff ^ port_latch_ff) & pin_en_ff); // [RULE_06] [RULE_07]

  // ==========================================================
  // core control register: set beats software clear
  always_comb begin
    nxt_core = core_ff;
    if (wr_core) begin
      nxt_core = wdata_ff;
    end
    if (I_EVENTS.timer_a_ovf) begin
      nxt_core[mief_pkg::B_TA_FLAG] = 1'b1; // [RULE_01] [RULE_04]
    end
    if (ext_edge) begin
      nxt_core[mief_pkg::B_EXT_FLAG] = 1'b1; // [RULE_05]
    end
    if (port_change) begin
      nxt_core[mief_pkg::B_PC_FLAG] = 1'b1; // [RULE_06]
    end
  end

  // flags only fall by a software write or a reset
  always_ff @(posedge I_CLK) begin
    if (rst) begin
      core_ff <= mief_pkg::RST_CORE; // [RULE_08]
    end else begin
      core_ff <= nxt_core; // [RULE_17]
    end
  end

  // ==========================================================
  // peripheral flags
  always_comb begin
    ev_periph = 8'h00;
    ev_periph[mief_pkg::B_EEPROM] = I_EVENTS.eeprom_done; // [RULE_09]
    ev_periph[mief_pkg::B_LOWV] = I_EVENTS.low_volt; // [RULE_10]
    ev_periph[mief_pkg::B_CIPHER] = I_EVENTS.cipher_done; // [RULE_11]
    ev_periph[mief_pkg::B_COMP_B] = HAS_COMP_B &&
      (I_EVENTS.comparator_b_output != comp_b_prev_ff); // [RULE_12]
    ev_periph[mief_pkg::B_COMP_A] =
      I_EVENTS.comparator_a_output != comp_a_prev_ff; // [RULE_13]
    ev_periph[mief_pkg::B_OSCF] = I_EVENTS.osc_fail; // [RULE_14]
    ev_periph[mief_pkg::B_TIMER_B] = I_EVENTS.timer_b_roll; // [RULE_15]
  end

  // write first, then events on top, then mask the unbuilt bit
  always_comb begin
    nxt_pflags = wr_pflags ? wdata_ff : pflags_ff;
    nxt_pflags = (nxt_pflags | ev_periph) &
      mief_pkg::PERIPH_MASK; // [RULE_01] [RULE_16]
  end

  // sticky peripheral flags
  always_ff @(posedge I_CLK) begin
    if (rst) begin
      pflags_ff <= mief_pkg::RST_PERIPH;
    end else begin
      pflags_ff <= nxt_pflags; // [RULE_17]
    end
  end

  // ==========================================================
  // enables and options
  always_ff @(posedge I_CLK) begin
    if (rst) begin
      pen_ff <= mief_pkg::RST_PERIPH;
      pin_en_ff <= mief_pkg::RST_PIN_EN;
      edge_sel_ff <= mief_pkg::RST_EDGE_SEL;
    end else begin
      if (wr_pen) begin
        pen_ff <= wdata_ff & mief_pkg::PERIPH_MASK; // [RULE_16]
      end
      if (do_write && wstrb0_ff && is_mapped(awaddr_ff) &&
          widx == mief_pkg::IDX_PIN_EN) begin
        pin_en_ff <= wdata_ff[5:0]; // [RULE_07]
      end
      if (do_write && wstrb0_ff && is_mapped(awaddr_ff) &&
          widx == mief_pkg::IDX_OPTION) begin
        edge_sel_ff <= wdata_ff[mief_pkg::B_EDGE_SEL]; // [RULE_20]
      end
    end
  end

  // ==========================================================
  // request to the core, registered for a clean output
  always_ff @(posedge I_CLK) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= core_ff[mief_pkg::B_GIE] && ( // [RULE_02] [RULE_21]
        |(core_ff[5:3] & core_ff[2:0]) ||
        (core_ff[mief_pkg::B_PERIPHERAL_IRQ_ENABLE] &&
         |(pen_ff & pflags_ff))); // [RULE_03]
    end
  end
  assign O_IRQ = irq_ff;

  // ==========================================================
  // checks
  a_timer_flag_set: assert property ( // [RULE_04]
    @(posedge I_CLK) disable iff (rst)
    I_EVENTS.timer_a_ovf |=> core_ff[mief_pkg::B_TA_FLAG])
    else $error("timer A flag not set after rollover");

  a_ext_edge_flag: assert property ( // [RULE_20]
    @(posedge I_CLK) disable iff (rst)
    (edge_sel_ff && ext_s2_ff && !ext_prev_ff) |=>
      core_ff[mief_pkg::B_EXT_FLAG])
    else $error("rising edge did not set external flag");

  a_port_pin_mask: assert property ( // [RULE_07]
    @(posedge I_CLK) disable iff (rst)
    (pin_en_ff == 6'h00 && !wr_core && !core_ff[mief_pkg::B_PC_FLAG])
      |=> !core_ff[mief_pkg::B_PC_FLAG])
    else $error("port flag set with no pin selected");

  a_flag_sticky: assert property ( // [RULE_17]
    @(posedge I_CLK) disable iff (rst)
    (pflags_ff[mief_pkg::B_EEPROM] && !wr_pflags) |=>
      pflags_ff[mief_pkg::B_EEPROM])
    else $error("peripheral flag dropped without a write");

  a_set_beats_clear: assert property ( // [RULE_01]
    @(posedge I_CLK) disable iff (rst)
    (wr_pflags && I_EVENTS.osc_fail) |=> pflags_ff[mief_pkg::B_OSCF])
    else $error("event lost under a clearing write");

  a_unbuilt_zero: assert property ( // [RULE_16]
    @(posedge I_CLK) disable iff (rst)
    !pflags_ff[mief_pkg::B_UNUSED] && !pen_ff[mief_pkg::B_UNUSED])
    else $error("unbuilt peripheral bit is set");

  a_global_gate: assert property ( // [RULE_02]
    @(posedge I_CLK) disable iff (rst)
    !core_ff[mief_pkg::B_GIE] [*2] |-> !O_IRQ)
    else $error("request raised with global enable off");

  a_periph_gate: assert property ( // [RULE_03]
    @(posedge I_CLK) disable iff (rst)
    (core_ff[mief_pkg::B_GIE] && !core_ff[mief_pkg::B_PERIPHERAL_IRQ_ENABLE] &&
     core_ff[2:0] == 3'h0) |=> !O_IRQ)
    else $error("peripheral request passed with its enable off");

  a_irq_raise: assert property ( // [RULE_21]
    @(posedge I_CLK) disable iff (rst)
    (core_ff[mief_pkg::B_GIE] && core_ff[mief_pkg::B_TA_EN] &&
     core_ff[mief_pkg::B_TA_FLAG]) |=> O_IRQ)
    else $error("enabled pending timer A gave no request");

  a_comp_change: assert property ( // [RULE_13]
    @(posedge I_CLK) disable iff (rst)
    $changed(I_EVENTS.comparator_a_output) |=>
      pflags_ff[mief_pkg::B_COMP_A])
    else $error("comparator A change not flagged");
endmodule
